// File: core/svc_regs.v
`timescale 1ns/1ps
`include "svc_defs.vh"

// How it works
// [R1] Per-channel enable and mute bits, reset zero.
// [R2] Left bit 13 defers gain to zero cross.
// [R3] Right bit 13 defers gain to zero cross.
// [R4] Written volumes wait pending until update strobe.
// [R5] Strobe in either register updates both channels.
// [R6] Right bit 10 enables inverting amplifier.
// [R7] Route bit zero feeds inverting amplifier.
// [R8] Route bit one feeds output driver; resets one.
// [R9] Six-bit volume at bits 7:2, reset 0dB.
// [R10] Beep register: enable bit 15, level 7:5.

module svc_regs #(
    parameter ADDR_W = 7,
    parameter DATA_W = 16,
    parameter GAIN_W = 6,
    parameter BEEP_W = 3
) (
    input wire core_clk,
    input wire rstn,
    input wire [ADDR_W-1:0] addr,
    input wire [DATA_W-1:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    output reg [DATA_W-1:0] rd_data,
    input wire left_zero_cross,
    input wire right_zero_cross,
    output wire left_out_b_enable,
    output wire left_out_b_silence,
    output wire [GAIN_W-1:0] left_out_b_gain,
    output wire right_out_b_enable,
    output wire right_out_b_silence,
    output wire [GAIN_W-1:0] right_out_b_gain,
    output reg right_inverting_amp_enable,
    output reg right_inverting_amp_route,
    output reg beep_path_enable,
    output reg [BEEP_W-1:0] beep_path_level
);

    // ************************************************************
    // Address decode.
    // ************************************************************
    wire hit_left;
    wire hit_right;
    wire hit_beep;
    wire [1:0] ch_hit;
    wire [1:0] ch_cross;
    wire update_strobe;

    assign hit_left = wr_en && (addr == `SVC_ADDR_LEFT);
    assign hit_right = wr_en && (addr == `SVC_ADDR_RIGHT);
    assign hit_beep = wr_en && (addr == `SVC_ADDR_BEEP);
    assign ch_hit = {hit_right, hit_left};
    assign ch_cross = {right_zero_cross, left_zero_cross};

    // The strobe bit is never stored, so it always reads back as zero.
    // [R5] shared update strobe
    assign update_strobe = (hit_left || hit_right) && wr_data[`SVC_BIT_UPDATE];

    // ************************************************************
    // Per-channel state.
    // ************************************************************
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1)
        begin : g_ch
            reg enable;
            reg silence;
            reg zc;
            reg [GAIN_W-1:0] pend_gain;
            reg [GAIN_W-1:0] target_gain;
            reg [GAIN_W-1:0] active_gain;
            reg armed;
            wire next_zc;
            wire [GAIN_W-1:0] next_pend;

            // A strobe write carries its own volume word, so the word
            // written beside the strobe is the one that gets latched.
            assign next_zc = ch_hit[ch] ? wr_data[`SVC_BIT_ZC] : zc;
            assign next_pend = ch_hit[ch] ? wr_data[`SVC_GAIN_HI:`SVC_GAIN_LO] : pend_gain;

            // [R1] enable and mute
            always @(posedge core_clk)
            begin
                if (!rstn)
                begin
                    enable <= 1'h0;
                    silence <= 1'h0;
                    zc <= 1'h0;
                end
                else if (ch_hit[ch])
                begin
                    enable <= wr_data[`SVC_BIT_ENABLE];
                    silence <= wr_data[`SVC_BIT_SILENCE];
                    zc <= wr_data[`SVC_BIT_ZC];
                end
            end

            // [R4] pending volume word
            always @(posedge core_clk)
            begin
                if (!rstn)
                begin
                    pend_gain <= `SVC_RST_GAIN;
                end
                else
                begin
                    pend_gain <= next_pend;
                end
            end

            // A later strobe replaces a target still waiting for its
            // crossing; a strobe beats a crossing in the same cycle.
            // [R2] [R3] zero-cross deferral
            always @(posedge core_clk)
            begin
                if (!rstn)
                begin
                    target_gain <= `SVC_RST_GAIN;
                    active_gain <= `SVC_RST_GAIN;
                    armed <= 1'h0;
                end
                else if (update_strobe)
                begin
                    target_gain <= next_pend;
                    if (next_zc)
                    begin
                        armed <= 1'h1;
                    end
                    else
                    begin
                        active_gain <= next_pend;
                        armed <= 1'h0;
                    end
                end
                else if (armed && (ch_cross[ch] || !next_zc))
                begin
                    active_gain <= target_gain;
                    armed <= 1'h0;
                end
            end
        end
    endgenerate

    assign left_out_b_enable = g_ch[0].enable;
    assign left_out_b_silence = g_ch[0].silence;
    assign left_out_b_gain = g_ch[0].active_gain;
    assign right_out_b_enable = g_ch[1].enable;
    assign right_out_b_silence = g_ch[1].silence;
    assign right_out_b_gain = g_ch[1].active_gain;

    // ************************************************************
    // Right amplifier options.
    // ************************************************************
    // [R6] inverting amplifier enable
    always @(posedge core_clk)
    begin
        if (!rstn)
        begin
            right_inverting_amp_enable <= 1'h0;
        end
        else if (hit_right)
        begin
            right_inverting_amp_enable <= wr_data[`SVC_BIT_INV_EN];
        end
    end

    // Zero sends the gain stage to the inverting amplifier, one to the
    // output driver; reset keeps the plain driver path.
    // [R7] [R8] gain stage routing
    always @(posedge core_clk)
    begin
        if (!rstn)
        begin
            right_inverting_amp_route <= `SVC_RST_ROUTE;
        end
        else if (hit_right)
        begin
            right_inverting_amp_route <= wr_data[`SVC_BIT_ROUTE];
        end
    end

    // ************************************************************
    // Beep mixer.
    // ************************************************************
    // [R10] beep enable and level
    always @(posedge core_clk)
    begin
        if (!rstn)
        begin
            beep_path_enable <= 1'h0;
            beep_path_level <= `SVC_RST_BEEP_LVL;
        end
        else if (hit_beep)
        begin
            beep_path_enable <= wr_data[`SVC_BIT_BEEP_EN];
            beep_path_level <= wr_data[`SVC_BEEP_HI:`SVC_BEEP_LO];
        end
    end

    // ************************************************************
    // Read back.
    // ************************************************************
    reg [DATA_W-1:0] next_rd_data;

    // Volume registers read back the pending word, not the live gain;
    // the live gains and the waiting flags sit in the status register.
    // [R9] volume field layout
    always @*
    begin
        next_rd_data = {DATA_W{1'b0}};
        if (rd_en)
        begin
            case (addr)
                `SVC_ADDR_LEFT:
                begin
                    next_rd_data[`SVC_BIT_ENABLE] = g_ch[0].enable;
                    next_rd_data[`SVC_BIT_SILENCE] = g_ch[0].silence;
                    next_rd_data[`SVC_BIT_ZC] = g_ch[0].zc;
                    next_rd_data[`SVC_GAIN_HI:`SVC_GAIN_LO] = g_ch[0].pend_gain;
                end
                `SVC_ADDR_RIGHT:
                begin
                    next_rd_data[`SVC_BIT_ENABLE] = g_ch[1].enable;
                    next_rd_data[`SVC_BIT_SILENCE] = g_ch[1].silence;
                    next_rd_data[`SVC_BIT_ZC] = g_ch[1].zc;
                    next_rd_data[`SVC_BIT_INV_EN] = right_inverting_amp_enable;
                    next_rd_data[`SVC_BIT_ROUTE] = right_inverting_amp_route;
                    next_rd_data[`SVC_GAIN_HI:`SVC_GAIN_LO] = g_ch[1].pend_gain;
                end
                `SVC_ADDR_STATUS:
                begin
                    next_rd_data[`SVC_STAT_LEFT_LO+GAIN_W-1:`SVC_STAT_LEFT_LO] = g_ch[0].active_gain;
                    next_rd_data[`SVC_STAT_RIGHT_LO+GAIN_W-1:`SVC_STAT_RIGHT_LO] = g_ch[1].active_gain;
                    next_rd_data[`SVC_STAT_WAIT_LO] = g_ch[0].armed;
                    next_rd_data[`SVC_STAT_WAIT_LO+1] = g_ch[1].armed;
                end
                `SVC_ADDR_BEEP:
                begin
                    next_rd_data[`SVC_BIT_BEEP_EN] = beep_path_enable;
                    next_rd_data[`SVC_BEEP_HI:`SVC_BEEP_LO] = beep_path_level;
                end
                default:
                begin
                    next_rd_data = {DATA_W{1'b0}};
                end
            endcase
        end
    end

    // Read data is held only for the cycle after the strobe.
    always @(posedge core_clk)
    begin
        if (!rstn)
        begin
            rd_data <= {DATA_W{1'b0}};
        end
        else
        begin
            rd_data <= next_rd_data;
        end
    end

endmodule // svc_regs

// File: inc/svc_defs.vh
`ifndef SVC_DEFS_VH
`define SVC_DEFS_VH

// ************************************************************
// Register indices on the control port.
// ************************************************************
`define SVC_ADDR_LEFT 7'h6A
`define SVC_ADDR_RIGHT 7'h6B
`define SVC_ADDR_STATUS 7'h6C
`define SVC_ADDR_BEEP 7'h6F

// ************************************************************
// Field positions in the volume registers.
// ************************************************************
`define SVC_BIT_ENABLE 15
`define SVC_BIT_SILENCE 14
`define SVC_BIT_ZC 13
`define SVC_BIT_INV_EN 10
`define SVC_BIT_ROUTE 9
`define SVC_BIT_UPDATE 8
`define SVC_GAIN_HI 7
`define SVC_GAIN_LO 2

// ************************************************************
// Field positions in the beep register.
// ************************************************************
`define SVC_BIT_BEEP_EN 15
`define SVC_BEEP_HI 7
`define SVC_BEEP_LO 5

// ************************************************************
// Field positions in the status register.
// ************************************************************
`define SVC_STAT_LEFT_LO 0
`define SVC_STAT_RIGHT_LO 6
`define SVC_STAT_WAIT_LO 12

// ************************************************************
// Reset values.
// ************************************************************
`define SVC_RST_GAIN 6'h39
`define SVC_RST_ROUTE 1'h1
`define SVC_RST_BEEP_LVL 3'h0

`endif

// File: tb/second_output_volume_ctrl_bench.sv
`timescale 1ns/1ps
// ************************************************************
// Bench for the output volume register bank.
// ************************************************************
module second_output_volume_ctrl_bench;
    logic core_clk = 0, rstn = 0, wr_en = 0, rd_en = 0, rd_q = 0, lzc = 0, rzc = 0;
    logic [6:0] addr = 0;
    logic [15:0] wr_data = 0, d, q[$];
    wire [15:0] rd_data;
    wire l_en, l_mute, r_en, r_mute, inv_en, route, beep_en;
    wire [5:0] l_gain, r_gain;
    wire [2:0] beep_lvl;
    integer err_count = 0, num_checks = 0, seed = 32'hB770, i;
    always #10 core_clk = ~core_clk;
    svc_regs dut_u (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .left_zero_cross(lzc), .right_zero_cross(rzc),
        .left_out_b_enable(l_en), .left_out_b_silence(l_mute), .left_out_b_gain(l_gain),
        .right_out_b_enable(r_en), .right_out_b_silence(r_mute), .right_out_b_gain(r_gain),
        .right_inverting_amp_enable(inv_en), .right_inverting_amp_route(route),
        .beep_path_enable(beep_en), .beep_path_level(beep_lvl));
    task cmp_rd(input logic [15:0] e);
        num_checks++;
        if (rd_data !== e)
        begin
            err_count++;
            $display("mismatch at %0t: read %h expected %h", $time, rd_data, e);
        end
    endtask
    task cmp_pin(input logic g, input logic e);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch at %0t: output level wrong", $time);
        end
    endtask
    task wr(input logic [6:0] a, input logic [15:0] v);
        @(posedge core_clk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1;
        @(posedge core_clk);
        wr_en <= 0;
    endtask
    task rd(input logic [6:0] a, input logic [15:0] e);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1;
        q.push_back(e);
        @(posedge core_clk);
        rd_en <= 0;
    endtask
    task reset_check;
        rstn <= 0;
        repeat (20) @(posedge core_clk);
        rstn <= 1;
        rd(7'h6A, 16'h00E4);
        rd(7'h6B, 16'h02E4);
        rd(7'h6F, 16'h0000);
        rd(7'h6C, 16'h0E79);
        rd(7'h00, 16'h0000);
        cmp_pin(route, 1'b1);
        cmp_pin(l_en | l_mute | r_en | r_mute | inv_en | beep_en, 1'b0);
    endtask
    task final_report;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        if (rd_q)
            cmp_rd(q.pop_front());
        rd_q <= rd_en;
    end
    initial
    begin
        #200000;
        err_count++;
        final_report();
    end
    initial
    begin
        reset_check();
        for (i = 0; i < 8; i++)
        begin
            d = $random(seed);
            d[13] = 0;
            d[8] = 1;
            wr(7'h6A, d);
            wr(7'h6C, ~d);
            rd(7'h6A, d & 16'hE0FC);
            rd(7'h6C, {4'h0, 6'h39, d[7:2]});
            cmp_pin(l_en, d[15]);
            cmp_pin(l_mute, d[14]);
        end
        wr(7'h6A, 16'h00A0);
        rd(7'h6C, {4'h0, 6'h39, d[7:2]});
        wr(7'h6B, 16'h0154);
        rd(7'h6C, 16'h0568);
        for (i = 0; i < 4; i++)
        begin
            wr(7'h6B, 16'h0054 | (i << 9) | (i << 14));
            rd(7'h6B, 16'h0054 | (i << 9) | (i << 14));
            cmp_pin(inv_en, i[1]);
            cmp_pin(route, i[0]);
            cmp_pin(r_en, i[1]);
            cmp_pin(r_mute, i[0]);
        end
        for (i = 0; i < 8; i++)
        begin
            d = 16'h7F1F | (i << 5) | (i[0] << 15);
            wr(7'h6F, d);
            rd(7'h6F, d & 16'h80E0);
            cmp_pin(beep_en, i[0]);
            cmp_pin(beep_lvl == i[2:0], 1'b1);
        end
        wr(7'h6B, 16'h20CC);
        wr(7'h6A, 16'h2110);
        rd(7'h6C, 16'h3568);
        rzc <= 1;
        @(posedge core_clk);
        rzc <= 0;
        rd(7'h6C, 16'h1CE8);
        lzc <= 1;
        wr(7'h6A, 16'h2164);
        @(posedge core_clk);
        lzc <= 0;
        rd(7'h6C, 16'h2CD9);
        reset_check();
        repeat (2) @(posedge core_clk);
        final_report();
    end
endmodule // second_output_volume_ctrl_bench

// File: tb/svc_regs_sva.sv
`timescale 1ns/1ps
// ************************************************************
// Port checker for the output volume register bank.
// ************************************************************
module svc_regs_sva (
    input wire core_clk,
    input wire rstn,
    input wire [6:0] addr,
    input wire [15:0] wr_data,
    input wire wr_en,
    input wire left_zero_cross,
    input wire left_out_b_enable,
    input wire [5:0] left_out_b_gain,
    input wire right_out_b_silence,
    input wire [5:0] right_out_b_gain,
    input wire right_inverting_amp_enable,
    input wire right_inverting_amp_route,
    input wire beep_path_enable,
    input wire [2:0] beep_path_level
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    wire wr_l = wr_en && addr == 7'h6A;
    wire wr_r = wr_en && addr == 7'h6B;
    wire wr_b = wr_en && addr == 7'h6F;
    sequence s_lzs;
        wr_l && wr_data[8] && wr_data[13];
    endsequence
    AST_EN: assert property (wr_l |=> left_out_b_enable == $past(wr_data[15]))
        else $error("left enable wrong");
    AST_MUTE: assert property (wr_r |=> right_out_b_silence == $past(wr_data[14]))
        else $error("right mute wrong");
    AST_LIMM: assert property (wr_l && wr_data[8] && !wr_data[13] |=> left_out_b_gain == $past(wr_data[7:2]))
        else $error("left gain not immediate");
    AST_RIMM: assert property (wr_r && wr_data[8] && !wr_data[13] |=> right_out_b_gain == $past(wr_data[7:2]))
        else $error("right gain not immediate");
    // A volume write in the cycle after the strobe may legally re-aim or release the
    // waiting gain, so both steps are only judged when the bus stays quiet.
    AST_LDEFER: assert property (s_lzs ##1 (!left_zero_cross && !wr_l && !wr_r) |=> left_out_b_gain == $past(left_out_b_gain, 2))
        else $error("left gain not deferred");
    AST_LAPPLY: assert property (s_lzs ##1 (left_zero_cross && !wr_l && !wr_r) |=> left_out_b_gain == $past(wr_data[7:2], 2))
        else $error("left gain not applied at crossing");
    AST_HOLD: assert property ($changed(left_out_b_gain) |-> $past(wr_en && (addr == 7'h6A || addr == 7'h6B)) || $past(left_zero_cross))
        else $error("left gain changed without cause");
    AST_INV: assert property (wr_r |=> right_inverting_amp_enable == $past(wr_data[10]))
        else $error("inverting enable wrong");
    AST_ROUTE: assert property (wr_r |=> right_inverting_amp_route == $past(wr_data[9]))
        else $error("route wrong");
    AST_BEEP: assert property (wr_b |=> {beep_path_enable, beep_path_level} == {$past(wr_data[15]), $past(wr_data[7:5])})
        else $error("beep fields wrong");
endmodule // svc_regs_sva

bind svc_regs svc_regs_sva chk_u (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .left_zero_cross(left_zero_cross), .left_out_b_enable(left_out_b_enable), .left_out_b_gain(left_out_b_gain),
    .right_out_b_silence(right_out_b_silence), .right_out_b_gain(right_out_b_gain),
    .right_inverting_amp_enable(right_inverting_amp_enable), .right_inverting_amp_route(right_inverting_amp_route),
    .beep_path_enable(beep_path_enable), .beep_path_level(beep_path_level));
